// file: edb_pkg.sv
// Shared constants and carrier types of the engine driver register bank.
// Assumes a 16-bit serial frame: write flag, space select, 4-bit index, byte.
`default_nettype none

package edb_pkg;

	// ------------------------------------------------------------
	// Serial frame layout
	// ------------------------------------------------------------
	localparam int FRAME_LEN = 16;               // Bits in one frame
	localparam int CNT_W     = 5;                // Bit counter width
	localparam int F_WRITE   = 15;               // One: write frame
	localparam int F_STATUS  = 14;               // One: status space
	localparam int F_IDX_HI  = 11;               // Register index msb
	localparam int F_IDX_LO  = 8;                // Register index lsb

	// ------------------------------------------------------------
	// Register indices, control space then status space
	// ------------------------------------------------------------
	localparam logic [3:0] IDX_MAIN   = 4'h0;    // output_enable_main
	localparam logic [3:0] IDX_MISC   = 4'h1;    // system_enable_misc
	localparam logic [3:0] IDX_DUTY0  = 4'h2;    // injector_one_duty
	localparam logic [3:0] IDX_DUTYN  = 4'hB;    // ignition_two_duty
	localparam logic [3:0] IDX_WDOG   = 4'hC;    // watchdog_refresh_load
	localparam logic [3:0] IDX_CRANK  = 4'hD;    // crank_sensor_params
	localparam logic [3:0] IDX_FLTN   = 4'h5;    // lamp_faults, last status
	localparam int         TACH_CH    = 4;       // tacho_faults channel

	// ------------------------------------------------------------
	// Field positions and masks
	// ------------------------------------------------------------
	localparam int MISC_PWR    = 7;              // Power enable, read only
	localparam int MISC_RST    = 0;              // Internal reset command
	localparam logic [7:0] MISC_RW_MASK = 8'h56; // Self test, supply, batsw, tach
	localparam int WD_REFRESH  = 7;              // Refresh trigger bit
	localparam int FLT_SUM     = 7;              // Summary fault flag
	localparam logic [3:0] SG_MASK_N = 4'hE;     // Drops short to ground
	localparam logic [7:0] RST_BYTE = 8'h00;     // Reset value of all bytes

	// ------------------------------------------------------------
	// Load time weights in milliseconds
	// ------------------------------------------------------------
	localparam logic [10:0] WD_W_SEC  = 11'h3E8; // One second
	localparam logic [10:0] WD_W_100  = 11'h064; // 100 ms
	localparam logic [10:0] WD_W_10   = 11'h00A; // 10 ms

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	localparam int FAULT_CH = 6;                 // Channels with fault bytes
	localparam int DUTY_CH  = 10;                // Channels with duty bytes

	typedef struct packed {
		logic open_load_flag;                    // Bit 3
		logic overcurrent_flag;                  // Bit 2
		logic overtemperature_flag;              // Bit 1
		logic short_to_ground_flag;              // Bit 0
	} edb_fault_s;

	typedef struct packed {
		logic sclk;                              // Serial clock pin
		logic csb;                               // Chip select, low active
		logic si;                                // Serial data in
	} edb_pins_s;

	typedef logic [DUTY_CH-1:0][6:0] edb_duty_t; // Duty per channel

endpackage : edb_pkg

`default_nettype wire

// file: edb_bank.sv
// Serial control and status register bank of the engine driver device.
// Assumes serial pins asynchronous to clock_i; faults and power enable
// arrive from filtered logic on clock_i. Serial clock must stay slow,
// each level held at least three clock_i periods.
//
// Function
// - Main byte: one enable per output
// - Reserved and unused bits read zero
// - Refresh bit acts on one, ignores zero
// - Refresh bit always reads zero
// - Cranking byte: threshold high, filter low
// - Fault byte: summary, open, over, temp, short
// - Tachometer fault byte lacks short flag
// - Flags clear by zero only once fault gone
`default_nettype none

module edb_bank (
	input  wire logic                   clock_i,            // 100 MHz
	input  wire logic                   reset_i,            // Async, high
	input  wire logic                   ce_i,               // Freezes state when low
	input  wire edb_pkg::edb_pins_s     pins_i,             // Serial pins
	output logic                        so_o,               // Serial data out
	input  wire logic                   power_enable_i,     // Power enable state
	input  wire edb_pkg::edb_fault_s [5:0] fault_raw_i,     // Live fault conditions
	output logic [7:0]                  out_enable_o,       // Main enables
	output logic                        self_test_en_o,     // Self test enable
	output logic                        sensor_supply_en_o, // Protected supply
	output logic                        battery_switch_en_o,// Battery switch
	output logic                        tacho_en_o,         // Tachometer
	output logic                        internal_reset_o,   // One-cycle pulse
	output edb_pkg::edb_duty_t          duty_o,             // Duty fields
	output logic                        wd_refresh_o,       // One-cycle pulse
	output logic [10:0]                 wd_load_ms_o,       // Load time in ms
	output logic [3:0]                  crank_threshold_o,  // Threshold code
	output logic [3:0]                  crank_filter_o      // Filter time code
);
	import edb_pkg::*;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Weighted load time; the binary nibble adds as is
	// The largest sum, 1125 ms, fits the eleven bits of the result
	function automatic logic [10:0] load_ms(input logic [6:0] f);
		load_ms = (f[6] ? WD_W_SEC : 11'h000) + (f[5] ? WD_W_100 : 11'h000)
			+ (f[4] ? WD_W_10 : 11'h000) + {7'h00, f[3:0]};
	endfunction

	// ------------------------------------------------------------
	// Pin synchroniser
	// ------------------------------------------------------------
	edb_pins_s s1_q;                // First stage, read by s2 only
	edb_pins_s s2_q;                // Stable copy
	edb_pins_s s3_q;                // Previous stable copy, for edges

	// Two flops before use, third only for edge detection
	// Edges are seen two clocks late, which is why the serial clock
	// must hold each level for at least three clock periods
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			s1_q <= '{sclk: 1'b0, csb: 1'b1, si: 1'b0};
			s2_q <= '{sclk: 1'b0, csb: 1'b1, si: 1'b0};
			s3_q <= '{sclk: 1'b0, csb: 1'b1, si: 1'b0};
		end else if (ce_i) begin
			s1_q <= pins_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// ------------------------------------------------------------
	// Frame decode
	// ------------------------------------------------------------
	wire logic       sel      = ~s2_q.csb;                  // Frame in progress
	wire logic       sck_rise = ce_i & sel & s2_q.sclk & ~s3_q.sclk;
	wire logic       sck_fall = ce_i & sel & ~s2_q.sclk & s3_q.sclk;
	wire logic       cs_fall  = ce_i & ~s2_q.csb & s3_q.csb;
	wire logic       cs_rise  = ce_i & s2_q.csb & ~s3_q.csb;

	logic [15:0]     rx_q;                                  // Shift in
	logic [15:0]     tx_q;                                  // Shift out
	logic [CNT_W-1:0] cnt_q;                                // Bits seen
	logic            so_q;                                  // Pin flop
	logic [7:0]      rdata_q;                               // Next answer

	// Only a frame of exactly 16 bits acts; others are dropped
	// A glitch on select restarts the count, so a torn frame never acts
	wire logic       exec   = cs_rise & (cnt_q == CNT_W'(FRAME_LEN));
	wire logic       wr     = exec & rx_q[F_WRITE];
	wire logic       stat   = rx_q[F_STATUS];
	wire logic [3:0] idx    = rx_q[F_IDX_HI:F_IDX_LO];
	wire logic [7:0] wdat   = rx_q[7:0];
	wire logic       wr_c   = wr & ~stat;                   // Control write
	wire logic       wr_s   = wr & stat;                    // Status write
	wire logic [3:0] didx   = idx - IDX_DUTY0;              // Duty channel
	wire logic       is_duty = (idx >= IDX_DUTY0) && (idx <= IDX_DUTYN);

	// Shift in on rising serial clock, count to a ceiling
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			rx_q  <= 16'h0000;
			cnt_q <= '0;
		end else if (cs_fall) begin
			cnt_q <= '0;
		end else if (sck_rise) begin
			rx_q  <= {rx_q[14:0], s2_q.si};
			cnt_q <= (cnt_q == '1) ? cnt_q : cnt_q + CNT_W'(1);
		end
	end

	// Answer loads at frame start, msb first, changes on falling clock
	// The upper byte is always zero; only the low byte carries data
	// After a full frame the line rests at zero until the next one
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			tx_q <= 16'h0000;
			so_q <= 1'b0;
		end else if (cs_fall) begin
			tx_q <= {8'h00, rdata_q};
			so_q <= 1'b0;
		end else if (sck_fall) begin
			tx_q <= {tx_q[14:0], 1'b0};
			so_q <= tx_q[14];
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	logic [7:0]      main_q;                                // Output enables
	logic [7:0]      misc_q;                                // Stored misc bits
	edb_duty_t       duty_q;                                // Duty fields
	logic [6:0]      wdog_q;                                // Load time fields
	logic [10:0]     load_q;                                // Decoded load time
	logic [7:0]      crank_q;                               // Cranking params
	logic            rst_pulse_q;                           // Reset command
	logic            refresh_q;                             // Refresh trigger

	// Plain byte stores
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			main_q  <= RST_BYTE;
			misc_q  <= RST_BYTE;
			crank_q <= RST_BYTE;
		end else if (ce_i) begin
			// Writes need a live enable anyway; the gate keeps the freeze explicit
			if (wr_c && idx == IDX_MAIN)
				main_q <= wdat;
			if (wr_c && idx == IDX_MISC)
				misc_q <= wdat & MISC_RW_MASK;
			if (wr_c && idx == IDX_CRANK)
				crank_q <= wdat;
		end
	end

	// Duty bytes keep only the low seven bits
	// A write outside the duty range never reaches this store
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			duty_q <= '0;
		end else if (wr_c && is_duty) begin
			duty_q[didx] <= wdat[6:0];
		end
	end

	// Watchdog byte; refresh is a pulse, never stored
	// Load time is decoded once here so the timer sees a plain count
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			wdog_q    <= 7'h00;
			load_q    <= 11'h000;
			refresh_q <= 1'b0;
		end else if (ce_i) begin
			refresh_q <= wr_c && idx == IDX_WDOG && wdat[WD_REFRESH];
			if (wr_c && idx == IDX_WDOG) begin
				wdog_q <= wdat[6:0];
				load_q <= load_ms(wdat[6:0]);
			end
		end
	end

	// Reset command only pulses; nothing reads it back
	// Whoever takes the pulse clears its own logic; no register here
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i)
			rst_pulse_q <= 1'b0;
		else if (ce_i)
			rst_pulse_q <= wr_c && idx == IDX_MISC && wdat[MISC_RST];
	end

	// ------------------------------------------------------------
	// Fault flags
	// ------------------------------------------------------------
	edb_fault_s [FAULT_CH-1:0] flag_q;                     // Latched flags
	logic [FAULT_CH-1:0]       sum_q;                      // Summary flags
	edb_fault_s [FAULT_CH-1:0] raw;                        // Masked conditions
	edb_fault_s [FAULT_CH-1:0] flag_d;
	logic [FAULT_CH-1:0]       sum_d;

	// Set wins over clear; a zero clears only a condition that is gone
	// A clear that meets a live condition is simply lost; the host must
	// write zero again once the condition has gone
	always_comb begin
		for (int c = 0; c < FAULT_CH; c++) begin
			raw[c] = (c == TACH_CH) ? (fault_raw_i[c] & SG_MASK_N)
				: fault_raw_i[c];
			flag_d[c] = raw[c] | (flag_q[c] & ~((wr_s && idx == 4'(c))
				? (~wdat[3:0] & ~raw[c]) : 4'h0));
			sum_d[c] = (|raw[c]) | (sum_q[c] & ~(wr_s && idx == 4'(c)
				&& !wdat[FLT_SUM] && !(|raw[c])));
		end
	end

	// Latch the flags
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			flag_q <= '0;
			sum_q  <= '0;
		end else if (ce_i) begin
			flag_q <= flag_d;
			sum_q  <= sum_d;
		end
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	// Unused and reserved bits read zero; misc ones are stored masked, the rest built as zero
	// Power enable is read live, never stored; its readback is latched only in the frame-end snapshot
	wire logic [7:0] misc_rd = {power_enable_i, misc_q[6:0]};
	wire logic [7:0] ctrl_rd =
		(idx == IDX_MAIN)  ? main_q :
		(idx == IDX_MISC)  ? misc_rd :
		is_duty            ? {1'b0, duty_q[didx]} :
		(idx == IDX_WDOG)  ? {1'b0, wdog_q} :
		(idx == IDX_CRANK) ? crank_q : 8'h00;
	wire logic [7:0] stat_rd = (idx <= IDX_FLTN)
		? {sum_q[idx[2:0]], 3'b000, flag_q[idx[2:0]]} : 8'h00;

	// Snapshot taken at frame end, shifted out by the next frame.
	// Trade-off: a write frame returns the value held before it.
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i)
			rdata_q <= 8'h00;
		else if (exec)
			rdata_q <= stat ? stat_rd : ctrl_rd;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Every output is a flop or a straight copy of one
	assign so_o                = so_q;
	assign out_enable_o        = main_q;
	assign self_test_en_o      = misc_q[6];
	assign sensor_supply_en_o  = misc_q[4];
	assign battery_switch_en_o = misc_q[2];
	assign tacho_en_o          = misc_q[1];
	assign internal_reset_o    = rst_pulse_q;
	assign duty_o              = duty_q;
	assign wd_refresh_o        = refresh_q;
	assign wd_load_ms_o        = load_q;
	assign crank_threshold_o   = crank_q[7:4];
	assign crank_filter_o      = crank_q[3:0];

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	// Register stores and command pulses

	a_main_write: assert property (wr_c && idx == IDX_MAIN |=> out_enable_o == $past(wdat))
		else $error("main enable byte not stored");
	a_misc_power: assert property (exec && !stat && idx == IDX_MISC
		|=> rdata_q[7] == $past(power_enable_i) && rdata_q[5] == 1'b0)
		else $error("misc readback wrong");
	a_reset_pulse: assert property (wr_c && idx == IDX_MISC && wdat[0]
		|=> internal_reset_o ##1 (!internal_reset_o || $past(wr_c)))
		else $error("reset command pulse wrong");
	a_reset_hidden: assert property (exec && !stat && idx == IDX_MISC |=> !rdata_q[0])
		else $error("reset bit read back");
	a_duty_write: assert property (wr_c && idx == IDX_DUTY0
		|=> duty_o[0] == $past(wdat[6:0]))
		else $error("duty byte not stored");
	a_duty_msb: assert property (exec && !stat && is_duty |=> !rdata_q[7])
		else $error("unused duty bit read as one");
	a_refresh_one: assert property (wr_c && idx == IDX_WDOG
		|=> wd_refresh_o == $past(wdat[WD_REFRESH]))
		else $error("refresh pulse mismatch");
	a_refresh_zero: assert property (exec && !stat && idx == IDX_WDOG |=> !rdata_q[7])
		else $error("refresh bit read as one");
	a_load_time: assert property (wr_c && idx == IDX_WDOG |=> wd_load_ms_o ==
		11'($past(wdat[6])) * 11'h3E8 + 11'($past(wdat[5])) * 11'h064
		+ 11'($past(wdat[4])) * 11'h00A + 11'($past(wdat[3:0])))
		else $error("load time sum wrong");
	a_crank_fields: assert property (wr_c && idx == IDX_CRANK
		|=> crank_threshold_o == $past(wdat[7:4]) && crank_filter_o == $past(wdat[3:0]))
		else $error("cranking fields wrong");

	// Fault bytes and latching
	a_fault_gap: assert property (exec && stat |=> rdata_q[6:4] == 3'b000)
		else $error("fault byte gap not zero");
	a_tach_no_sg: assert property (!flag_q[TACH_CH].short_to_ground_flag)
		else $error("tachometer short flag set");
	a_flag_held: assert property (ce_i && fault_raw_i[0].open_load_flag
		|=> flag_q[0].open_load_flag && sum_q[0])
		else $error("live fault flag lost");
	a_flag_clear: assert property (wr_s && idx == 4'h0 && !wdat[3]
		&& !fault_raw_i[0].open_load_flag |=> !flag_q[0].open_load_flag)
		else $error("open load flag not cleared");
	a_sum_kept: assert property (wr_s && idx == 4'h0 && (|fault_raw_i[0])
		|=> sum_q[0])
		else $error("summary flag cleared while fault live");

	// Refused frames, unmapped reads and the single refresh pulse
	a_short_drop: assert property (cs_rise && cnt_q != CNT_W'(FRAME_LEN)
		|=> $stable(rdata_q) && $stable(out_enable_o))
		else $error("frame of wrong length acted");
	a_unmapped_ctl: assert property (exec && !stat && idx > IDX_CRANK
		|=> rdata_q == 8'h00)
		else $error("unmapped control index read nonzero");
	a_unmapped_stat: assert property (exec && stat && idx > IDX_FLTN
		|=> rdata_q == 8'h00)
		else $error("unmapped status index read nonzero");
	a_refresh_single: assert property (wd_refresh_o
		|=> !wd_refresh_o || $past(wr_c))
		else $error("refresh pulse stretched");

	c_write_frame: cover property (wr_c && idx == IDX_MAIN);
	c_fault_clear: cover property (sum_q[0] ##1 !sum_q[0]);
	c_refresh:     cover property (wd_refresh_o);
	c_status_read: cover property (exec && stat && !rx_q[F_WRITE]);
	c_short_drop:  cover property (cs_rise && cnt_q != CNT_W'(FRAME_LEN));

endmodule : edb_bank

`default_nettype wire

// file: edb_mcu_model.sv
// Microcontroller side of the serial link: sends frames, gathers answers.
// Assumes clock_i is the bank clock; pins move 1 ns after its rising edge.
`default_nettype none

module edb_mcu_model (
	input  wire logic          clock_i, // Bank clock
	input  wire logic          so_i,    // Answer line from the bank
	output edb_pkg::edb_pins_s pins_o,  // Serial pins to the bank
	output logic               done_o,  // One cycle, answer valid
	output logic [15:0]        resp_o   // Answer of the last full frame
);
	timeunit 1ns;
	timeprecision 100ps;
	import edb_pkg::*;

	// ------------------------------------------------------------
	// Serial master
	// ------------------------------------------------------------
	localparam int HALF = 4; // Clocks per phase, one above the minimum

	// Idle: clock low, select high
	initial begin
		pins_o = '{sclk: 1'b0, csb: 1'b1, si: 1'b1};
		done_o = 1'b0;
		resp_o = 16'h0000;
	end

	// One frame, msb first; short frames yield no answer
	task automatic xfer(input logic [15:0] frame, input int nbits);
		logic [15:0] sh;
		sh = 16'h0000;
		@(posedge clock_i) #1 pins_o.csb = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			pins_o.si = frame[15-i];
			repeat (HALF) @(posedge clock_i);
			// Answer bit settled three clocks after the fall
			#1 sh = {sh[14:0], so_i};
			pins_o.sclk = 1'b1;
			repeat (HALF) @(posedge clock_i);
			#1 pins_o.sclk = 1'b0;
		end
		repeat (HALF) @(posedge clock_i);
		#1 pins_o.csb = 1'b1;
		// Released data line must not keep the last bit
		pins_o.si = ~pins_o.si;
		if (nbits == FRAME_LEN) begin
			resp_o = sh;
			done_o = 1'b1;
			@(posedge clock_i) #1 done_o = 1'b0;
		end
		repeat (HALF) @(posedge clock_i);
	endtask
endmodule // edb_mcu_model

`default_nettype wire

// file: testbench.sv
// Self-checking bench of the register bank, driven through the link model.
// Assumes edb_pkg, edb_bank and edb_mcu_model are compiled first.
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import edb_pkg::*;

`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin fail_count++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, ex, gt); end end

	// ------------------------------------------------------------
	// Signals and mirror
	// ------------------------------------------------------------
	logic clock_i, reset_i, ce_i, power_enable_i, so_o, done;
	logic [7:0]             out_enable_o;
	logic self_test_en_o, sensor_supply_en_o, battery_switch_en_o, tacho_en_o;
	logic internal_reset_o, wd_refresh_o;
	logic [10:0]            wd_load_ms_o;
	logic [3:0]             crank_threshold_o, crank_filter_o;
	edb_pins_s              pins;
	edb_fault_s [5:0]       fault_raw;
	edb_duty_t              duty_o;
	logic [15:0]            resp, exp_w;
	logic [15:0]            expq[$];  // Expected answers, oldest first
	logic [7:0]             ctl [16]; // Control space mirror
	logic [7:0]             st [6];   // Fault flag mirror
	logic [7:0]             pend;     // Read byte due in the next answer
	int fail_count, compares, seed, n_rst, n_ref, k;

	edb_bank u_edb_bank (.clock_i(clock_i), .reset_i(reset_i), .ce_i(ce_i), .pins_i(pins),
		.so_o(so_o), .power_enable_i(power_enable_i), .fault_raw_i(fault_raw),
		.out_enable_o(out_enable_o), .self_test_en_o(self_test_en_o),
		.sensor_supply_en_o(sensor_supply_en_o), .battery_switch_en_o(battery_switch_en_o),
		.tacho_en_o(tacho_en_o), .internal_reset_o(internal_reset_o), .duty_o(duty_o),
		.wd_refresh_o(wd_refresh_o), .wd_load_ms_o(wd_load_ms_o),
		.crank_threshold_o(crank_threshold_o), .crank_filter_o(crank_filter_o));

	edb_mcu_model u_edb_mcu_model (.clock_i(clock_i), .so_i(so_o), .pins_o(pins),
		.done_o(done), .resp_o(resp));

	// ------------------------------------------------------------
	// Reference helpers
	// ------------------------------------------------------------
	// Live conditions as flag byte; tach has no short flag
	function automatic logic [7:0] raw_byte(int ch);
		logic [3:0] m;
		m = fault_raw[ch] & ((ch == TACH_CH) ? SG_MASK_N : 4'hF);
		raw_byte = {|m, 3'b000, m};
	endfunction

	// Expected read byte; unmapped places read zero
	function automatic logic [7:0] exp_rd(logic sp, logic [3:0] idx);
		if (sp) exp_rd = (idx <= IDX_FLTN) ? st[idx] : 8'h00;
		else if (idx > IDX_CRANK) exp_rd = 8'h00;
		else if (idx == IDX_MISC) exp_rd = ctl[idx] | {power_enable_i, 7'h00};
		else exp_rd = ctl[idx];
	endfunction

	// Writable bits per control index
	function automatic logic [7:0] wmask(logic [3:0] idx);
		if (idx == IDX_MAIN || idx == IDX_CRANK) wmask = 8'hFF;
		else if (idx == IDX_MISC) wmask = MISC_RW_MASK;
		else wmask = 8'h7F;
	endfunction

	// One frame; answer of this frame is the previous read byte
	task automatic access(input logic wr, input logic sp, input logic [3:0] idx,
			input logic [7:0] d);
		expq.push_back({8'h00, pend});
		pend = exp_rd(sp, idx);
		if (wr && !sp && idx <= IDX_CRANK) ctl[idx] = d & wmask(idx);
		if (wr && sp && idx <= IDX_FLTN) st[idx] = st[idx] & (d | raw_byte(int'(idx)));
		u_edb_mcu_model.xfer({wr, sp, 2'b00, idx, d}, FRAME_LEN);
		repeat (6) @(posedge clock_i);
		#1;
	endtask

	// Raise conditions long enough for the flags to latch
	task automatic set_raw(int ch, logic [3:0] v);
		fault_raw[ch] = v;
		repeat (3) @(posedge clock_i);
		#1 st[ch] = st[ch] | raw_byte(ch);
	endtask

	// Decoded outputs against the mirror
	task automatic check_outs();
		logic [7:0] c;
		c = ctl[IDX_WDOG];
		`CHK("out_enable", ctl[0], out_enable_o)
		`CHK("self_test", ctl[1][6], self_test_en_o)
		`CHK("sensor_supply", ctl[1][4], sensor_supply_en_o)
		`CHK("battery_switch", ctl[1][2], battery_switch_en_o)
		`CHK("tacho", ctl[1][1], tacho_en_o)
		for (int i = 0; i < DUTY_CH; i++) `CHK("duty", ctl[i+2][6:0], duty_o[i])
		`CHK("load_ms", (c[6] ? WD_W_SEC : 11'h000) + (c[5] ? WD_W_100 : 11'h000) + (c[4] ?
			WD_W_10 : 11'h000) + {7'h00, c[3:0]}, wd_load_ms_o)
		`CHK("threshold", ctl[13][7:4], crank_threshold_o)
		`CHK("filter", ctl[13][3:0], crank_filter_o)
	endtask

	// Verdict, reached from the sequence or the watchdog
	task automatic end_of_test();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Clock, monitor, watchdog
	// ------------------------------------------------------------
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	// Pulse counts and answer scoreboard
	always @(posedge clock_i) begin
		if (internal_reset_o === 1'b1) n_rst++;
		if (wd_refresh_o === 1'b1) n_ref++;
		if (done === 1'b1) begin
			exp_w = expq.pop_front();
			`CHK("answer", exp_w, resp)
		end
	end

	// About 100 frames of 150 clocks; generous margin
	initial begin
		repeat (40000) @(posedge clock_i);
		fail_count++;
		$display("[FAIL] watchdog expired before the sequence ended");
		end_of_test();
	end

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		reset_i = 1'b1;
		ce_i = 1'b1; // Held high except for the one full frame sent frozen in the short frames test
		power_enable_i = 1'b0;
		fault_raw = '0;
		pend = 8'h00;
		seed = 32'haa8b;
		foreach (ctl[i]) ctl[i] = RST_BYTE;
		foreach (st[i]) st[i] = RST_BYTE;
		repeat (6) @(posedge clock_i);
		#1 reset_i = 1'b0;
		// Reset values over both spaces, unmapped included
		for (int i = 0; i < 16; i++) access(1'b0, 1'b0, i[3:0], 8'h00);
		for (int i = 0; i < 8; i++) access(1'b0, 1'b1, i[3:0], 8'h00);
		check_outs();
		$display("test reset_values done");
		// Random writes over the whole control space, then read back
		power_enable_i = 1'b1;
		for (int i = 0; i < 16; i++) access(1'b1, 1'b0, i[3:0], 8'($random(seed)));
		access(1'b1, 1'b1, 4'h7, 8'hFF); // Status write past the last fault byte
		check_outs();
		for (int i = 0; i < 16; i++) access(1'b0, 1'b0, i[3:0], 8'h00);
		$display("test random_rw done");
		// Command pulses; refresh ignores zero
		k = n_rst;
		access(1'b1, 1'b0, IDX_MISC, 8'hFF);
		`CHK("internal_reset", k + 1, n_rst)
		k = n_ref;
		access(1'b1, 1'b0, IDX_WDOG, 8'hFF);
		`CHK("refresh_one", k + 1, n_ref)
		access(1'b1, 1'b0, IDX_WDOG, 8'h7A);
		`CHK("refresh_zero", k + 1, n_ref)
		access(1'b0, 1'b0, IDX_WDOG, 8'h00);
		check_outs();
		$display("test pulses done");
		// Fault latch, refused clear, ones ignored, clear
		for (int ch = 0; ch < FAULT_CH; ch++) begin
			set_raw(ch, 4'hF);
			access(1'b1, 1'b1, ch[3:0], 8'h00);
			fault_raw[ch] = 4'h0;
			access(1'b1, 1'b1, ch[3:0], 8'hFF);
			access(1'b0, 1'b1, ch[3:0], 8'h00);
			access(1'b1, 1'b1, ch[3:0], 8'h00);
			access(1'b0, 1'b1, ch[3:0], 8'h00);
		end
		// Short to ground alone raises nothing on the tachometer
		set_raw(TACH_CH, 4'h1);
		access(1'b0, 1'b1, 4'(TACH_CH), 8'h00);
		fault_raw[TACH_CH] = 4'h0;
		$display("test faults done");
		// Frames of wrong length, or sent while frozen, change nothing
		ce_i = 1'b0;
		expq.push_back(16'h0000); // Frozen line rests at zero after a full frame
		u_edb_mcu_model.xfer({2'b10, 2'b00, IDX_MAIN, ~ctl[0]}, FRAME_LEN);
		#1 ce_i = 1'b1;
		u_edb_mcu_model.xfer({2'b10, 2'b00, IDX_MAIN, ~ctl[0]}, 15);
		u_edb_mcu_model.xfer({2'b10, 2'b00, IDX_MAIN, ~ctl[0]}, 8);
		repeat (6) @(posedge clock_i);
		#1;
		check_outs();
		access(1'b0, 1'b0, IDX_MAIN, 8'h00);
		access(1'b0, 1'b0, IDX_MAIN, 8'h00);
		$display("test short_frames done");
		end_of_test();
	end
endmodule // testbench

`default_nettype wire
